// ### pkg/dcs_defs.vh
// Command codes, page sizes and command spacing counts for the spacing gate
`ifndef DCS_DEFS_VH
`define DCS_DEFS_VH

`define DCS_CLK_PS          100000
`define DCS_CEIL(ps)        (((ps) + `DCS_CLK_PS - 1) / `DCS_CLK_PS)
`define DCS_MAX(a, b)       (((a) > (b)) ? (a) : (b))

`define DCS_CMD_OTHER       2'h0
`define DCS_CMD_ACT         2'h1
`define DCS_CMD_RD          2'h2
`define DCS_CMD_WR          2'h3

`define DCS_PAGE_HALF       2'h0
`define DCS_PAGE_1K         2'h1
`define DCS_PAGE_2K         2'h2

`define DCS_GROUPS          4
`define DCS_FAW_SLOTS       4
`define DCS_CNT_W           5
`define DCS_CNT_ZERO        5'h00
`define DCS_CNT_ONE         5'h01

`define DCS_CCD_L_NCK       4
`define DCS_CCD_L_PS        5355
`define DCS_CCD_S_NCK       4
`define DCS_RRD_NCK         4
`define DCS_RRD_S_2K_PS     5300
`define DCS_RRD_S_1K_PS     3700
`define DCS_RRD_S_HK_PS     3700
`define DCS_RRD_L_2K_PS     6400
`define DCS_RRD_L_1K_PS     5300
`define DCS_RRD_L_HK_PS     5300
`define DCS_FAW_2K_NCK      28
`define DCS_FAW_2K_PS       30000
`define DCS_FAW_1K_NCK      20
`define DCS_FAW_1K_PS       21000
`define DCS_FAW_HK_NCK      16
`define DCS_FAW_HK_PS       15000
`define DCS_WTR_S_NCK       2
`define DCS_WTR_S_PS        2500

`define DCS_CAUSE_W         6
`define DCS_CAUSE_COL_SAME  0
`define DCS_CAUSE_COL_OTHER 1
`define DCS_CAUSE_ACT_SAME  2
`define DCS_CAUSE_ACT_OTHER 3
`define DCS_CAUSE_FAW       4
`define DCS_CAUSE_WTR       5

`endif

// ### logic/dcs_faw.v
// Rolling four-activation window tracker
`default_nettype none
`timescale 1ns/10ps
`include "dcs_defs.vh"

module dcs_faw (
  input  wire                   clk,
  input  wire                   rst_n,
  input  wire                   act_fire,
  input  wire [`DCS_CNT_W-1:0]  window_cyc,
  output wire                   slot_free
);

  wire [`DCS_FAW_SLOTS-1:0] free_w;
  wire [`DCS_FAW_SLOTS-1:0] pick_w;

  // Lowest free slot takes the new activation
  assign pick_w    = free_w & (~free_w + 4'h1);
  assign slot_free = |free_w; // see [R7] [R8] [R9]

  genvar s;
  generate
    for (s = 0; s < `DCS_FAW_SLOTS; s = s + 1) begin : slot
      reg [`DCS_CNT_W-1:0] age_q;
      assign free_w[s] = (age_q == `DCS_CNT_ZERO);
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          age_q <= `DCS_CNT_ZERO;
        end else if (act_fire && pick_w[s]) begin
          age_q <= window_cyc - `DCS_CNT_ONE; // see [R7] [R8] [R9]
        end else if (!free_w[s]) begin
          age_q <= age_q - `DCS_CNT_ONE;
        end
      end
    end
  endgenerate

endmodule // dcs_faw
`default_nettype wire

// ### logic/dcs_spacing.v
// Command spacing gate placed in front of a DDR4 command issue path
//
// Operation
// [R1] Column commands to one bank group are spaced by at least max(4 cycles, 5.355 ns).
// [R2] Column commands to different bank groups are spaced by at least 4 cycles.
// [R3] Activations to different groups wait max(4 cycles, 5.3 ns) on 2KB pages or max(4, 3.7 ns) on 1KB.
// [R4] Activations to different groups on half-kilobyte pages wait max(4 cycles, 3.7 ns).
// [R5] Activations within one group wait max(4 cycles, 6.4 ns) on 2KB pages or max(4, 5.3 ns) on 1KB.
// [R6] Activations within one group on half-kilobyte pages wait max(4 cycles, 5.3 ns).
// [R7] On 2KB pages at most four activations fall in any window of max(28 cycles, 30 ns).
// [R8] On 1KB pages at most four activations fall in any window of max(20 cycles, 21 ns).
// [R9] On half-kilobyte pages at most four activations fall in any window of max(16 cycles, 15 ns).
// [R10] A read to another group waits max(2 cycles, 2.5 ns) after a write begins.
// [R11] Each time limit is rounded up to whole cycles and the larger of it and the cycle count applies.
// [R12] Last column and last activation are tracked per group and across groups; activation history only across groups.
`default_nettype none
`timescale 1ns/10ps
`include "dcs_defs.vh"

module dcs_spacing (
  input  wire                    MCLK,
  input  wire                    RESETN,
  input  wire [1:0]              PAGE_SIZE,
  input  wire                    REQ_VALID,
  input  wire [1:0]              REQ_CMD,
  input  wire [1:0]              REQ_BG,
  input  wire [17:0]             REQ_ADDR,
  output wire                    REQ_READY,
  output reg                     CMD_VALID,
  output reg  [1:0]              CMD_TYPE,
  output reg  [1:0]              CMD_BG,
  output reg  [17:0]             CMD_ADDR,
  output reg  [`DCS_CAUSE_W-1:0] BLOCK_CAUSE
);

  // Cycle counts; at slow clocks the cycle minimum dominates
  localparam integer CCD_L_INT  = `DCS_MAX(`DCS_CCD_L_NCK, `DCS_CEIL(`DCS_CCD_L_PS));    // see [R1] [R11]
  localparam integer CCD_S_INT  = `DCS_CCD_S_NCK;                                       // see [R2]
  localparam integer RRDS2K_INT = `DCS_MAX(`DCS_RRD_NCK, `DCS_CEIL(`DCS_RRD_S_2K_PS));   // see [R3] [R11]
  localparam integer RRDS1K_INT = `DCS_MAX(`DCS_RRD_NCK, `DCS_CEIL(`DCS_RRD_S_1K_PS));   // see [R3] [R11]
  localparam integer RRDSHK_INT = `DCS_MAX(`DCS_RRD_NCK, `DCS_CEIL(`DCS_RRD_S_HK_PS));   // see [R4] [R11]
  localparam integer RRDL2K_INT = `DCS_MAX(`DCS_RRD_NCK, `DCS_CEIL(`DCS_RRD_L_2K_PS));   // see [R5] [R11]
  localparam integer RRDL1K_INT = `DCS_MAX(`DCS_RRD_NCK, `DCS_CEIL(`DCS_RRD_L_1K_PS));   // see [R5] [R11]
  localparam integer RRDLHK_INT = `DCS_MAX(`DCS_RRD_NCK, `DCS_CEIL(`DCS_RRD_L_HK_PS));   // see [R6] [R11]
  localparam integer FAW2K_INT  = `DCS_MAX(`DCS_FAW_2K_NCK, `DCS_CEIL(`DCS_FAW_2K_PS));  // see [R7] [R11]
  localparam integer FAW1K_INT  = `DCS_MAX(`DCS_FAW_1K_NCK, `DCS_CEIL(`DCS_FAW_1K_PS));  // see [R8] [R11]
  localparam integer FAWHK_INT  = `DCS_MAX(`DCS_FAW_HK_NCK, `DCS_CEIL(`DCS_FAW_HK_PS));  // see [R9] [R11]
  localparam integer WTR_S_INT  = `DCS_MAX(`DCS_WTR_S_NCK, `DCS_CEIL(`DCS_WTR_S_PS));    // see [R10] [R11]

  // Cut to counter width on purpose; the longest count, the 2KB window, still fits
  localparam [`DCS_CNT_W-1:0] CCD_L_CYC  = CCD_L_INT[`DCS_CNT_W-1:0];
  localparam [`DCS_CNT_W-1:0] CCD_S_CYC  = CCD_S_INT[`DCS_CNT_W-1:0];
  localparam [`DCS_CNT_W-1:0] RRDS2K_CYC = RRDS2K_INT[`DCS_CNT_W-1:0];
  localparam [`DCS_CNT_W-1:0] RRDS1K_CYC = RRDS1K_INT[`DCS_CNT_W-1:0];
  localparam [`DCS_CNT_W-1:0] RRDSHK_CYC = RRDSHK_INT[`DCS_CNT_W-1:0];
  localparam [`DCS_CNT_W-1:0] RRDL2K_CYC = RRDL2K_INT[`DCS_CNT_W-1:0];
  localparam [`DCS_CNT_W-1:0] RRDL1K_CYC = RRDL1K_INT[`DCS_CNT_W-1:0];
  localparam [`DCS_CNT_W-1:0] RRDLHK_CYC = RRDLHK_INT[`DCS_CNT_W-1:0];
  localparam [`DCS_CNT_W-1:0] FAW2K_CYC  = FAW2K_INT[`DCS_CNT_W-1:0];
  localparam [`DCS_CNT_W-1:0] FAW1K_CYC  = FAW1K_INT[`DCS_CNT_W-1:0];
  localparam [`DCS_CNT_W-1:0] FAWHK_CYC  = FAWHK_INT[`DCS_CNT_W-1:0];
  localparam [`DCS_CNT_W-1:0] WTR_S_CYC  = WTR_S_INT[`DCS_CNT_W-1:0];

  reg  [`DCS_CNT_W-1:0]   column_gap_other_group_q;
  reg  [`DCS_CNT_W-1:0]   activate_gap_other_group_q;
  reg  [`DCS_CNT_W-1:0]   rrd_s_cyc;
  reg  [`DCS_CNT_W-1:0]   rrd_l_cyc;
  reg  [`DCS_CNT_W-1:0]   faw_cyc;
  reg  [`DCS_CAUSE_W-1:0] cause_d;

  wire [`DCS_GROUPS-1:0]  col_free;
  wire [`DCS_GROUPS-1:0]  act_free;
  wire [`DCS_GROUPS-1:0]  wtr_busy;
  wire [`DCS_GROUPS-1:0]  req_sel;
  wire                    is_act;
  wire                    is_col;
  wire                    is_rd;
  wire                    is_wr;
  wire                    faw_free;
  wire                    issue;
  wire                    col_other_busy;
  wire                    act_other_busy;

  assign is_act  = (REQ_CMD == `DCS_CMD_ACT);
  assign is_rd   = (REQ_CMD == `DCS_CMD_RD);
  assign is_wr   = (REQ_CMD == `DCS_CMD_WR);
  assign is_col  = is_rd | is_wr;
  assign req_sel = 4'h1 << REQ_BG;
  assign issue   = REQ_VALID & REQ_READY;

  assign col_other_busy = (column_gap_other_group_q != `DCS_CNT_ZERO);   // see [R2]
  assign act_other_busy = (activate_gap_other_group_q != `DCS_CNT_ZERO); // see [R3] [R4]

  // Unknown page code falls back to 2KB, the most conservative set
  always @* begin
    case (PAGE_SIZE)
      `DCS_PAGE_HALF: begin
        rrd_s_cyc = RRDSHK_CYC; // see [R4]
        rrd_l_cyc = RRDLHK_CYC; // see [R6]
        faw_cyc   = FAWHK_CYC;  // see [R9]
      end
      `DCS_PAGE_1K: begin
        rrd_s_cyc = RRDS1K_CYC; // see [R3]
        rrd_l_cyc = RRDL1K_CYC; // see [R5]
        faw_cyc   = FAW1K_CYC;  // see [R8]
      end
      default: begin
        rrd_s_cyc = RRDS2K_CYC; // see [R3]
        rrd_l_cyc = RRDL2K_CYC; // see [R5]
        faw_cyc   = FAW2K_CYC;  // see [R7]
      end
    endcase
  end

  // Same-group write-to-read wait is left to the issuer; only the cross-group one is held
  // Per-group history: last column, last activation, last write start
  genvar g;
  generate
    for (g = 0; g < `DCS_GROUPS; g = g + 1) begin : grp
      reg  [`DCS_CNT_W-1:0] column_gap_same_group_q;
      reg  [`DCS_CNT_W-1:0] activate_gap_same_group_q;
      reg  [`DCS_CNT_W-1:0] write_to_read_other_group_q;
      wire                  hit;

      assign hit         = issue & req_sel[g];
      assign col_free[g] = (column_gap_same_group_q == `DCS_CNT_ZERO);
      assign act_free[g] = (activate_gap_same_group_q == `DCS_CNT_ZERO);
      assign wtr_busy[g] = (write_to_read_other_group_q != `DCS_CNT_ZERO);

      always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
          column_gap_same_group_q     <= `DCS_CNT_ZERO;
          activate_gap_same_group_q   <= `DCS_CNT_ZERO;
          write_to_read_other_group_q <= `DCS_CNT_ZERO;
        end else begin
          if (hit && is_col) begin
            column_gap_same_group_q <= CCD_L_CYC - `DCS_CNT_ONE; // see [R1] [R12]
          end else if (!col_free[g]) begin
            column_gap_same_group_q <= column_gap_same_group_q - `DCS_CNT_ONE;
          end
          if (hit && is_act) begin
            activate_gap_same_group_q <= rrd_l_cyc - `DCS_CNT_ONE; // see [R5] [R6] [R12]
          end else if (!act_free[g]) begin
            activate_gap_same_group_q <= activate_gap_same_group_q - `DCS_CNT_ONE;
          end
          // Write command taken as the start of the internal write, the early and safe end
          if (hit && is_wr) begin
            write_to_read_other_group_q <= WTR_S_CYC - `DCS_CNT_ONE; // see [R10] [R12]
          end else if (wtr_busy[g]) begin
            write_to_read_other_group_q <= write_to_read_other_group_q - `DCS_CNT_ONE;
          end
        end
      end
    end
  endgenerate

  // Cross-group spacing; same-group limits are never shorter, so one counter serves
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      column_gap_other_group_q   <= `DCS_CNT_ZERO;
      activate_gap_other_group_q <= `DCS_CNT_ZERO;
    end else begin
      if (issue && is_col) begin
        column_gap_other_group_q <= CCD_S_CYC - `DCS_CNT_ONE; // see [R2] [R12]
      end else if (col_other_busy) begin
        column_gap_other_group_q <= column_gap_other_group_q - `DCS_CNT_ONE;
      end
      if (issue && is_act) begin
        activate_gap_other_group_q <= rrd_s_cyc - `DCS_CNT_ONE; // see [R3] [R4] [R12]
      end else if (act_other_busy) begin
        activate_gap_other_group_q <= activate_gap_other_group_q - `DCS_CNT_ONE;
      end
    end
  end

  // Slots reload from the live page size; change it only while the window is drained
  dcs_faw u_faw (
    .clk        (MCLK),
    .rst_n      (RESETN),
    .act_fire   (issue & is_act),
    .window_cyc (faw_cyc),
    .slot_free  (faw_free)
  );

  // Stall causes for the request at the head
  always @* begin
    cause_d                         = {`DCS_CAUSE_W{1'b0}};
    cause_d[`DCS_CAUSE_COL_SAME]    = is_col & ~col_free[REQ_BG];                      // see [R1]
    cause_d[`DCS_CAUSE_COL_OTHER]   = is_col & col_other_busy;                        // see [R2]
    cause_d[`DCS_CAUSE_ACT_SAME]    = is_act & ~act_free[REQ_BG];                      // see [R5] [R6]
    cause_d[`DCS_CAUSE_ACT_OTHER]   = is_act & act_other_busy;                        // see [R3] [R4]
    cause_d[`DCS_CAUSE_FAW]         = is_act & ~faw_free;                              // see [R7] [R8] [R9]
    cause_d[`DCS_CAUSE_WTR]         = is_rd & (|(wtr_busy & ~req_sel));                // see [R10]
  end

  // Other commands pass unchecked; ready does not wait for valid
  assign REQ_READY = ~(|cause_d);

  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      CMD_VALID   <= 1'b0;
      BLOCK_CAUSE <= {`DCS_CAUSE_W{1'b0}};
    end else begin
      CMD_VALID   <= issue;
      BLOCK_CAUSE <= REQ_VALID ? cause_d : {`DCS_CAUSE_W{1'b0}};
    end
  end

  // Payload holds between accepts, so a slow consumer may still read it late
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      CMD_TYPE <= `DCS_CMD_OTHER;
      CMD_BG   <= 2'h0;
      CMD_ADDR <= 18'h0_0000;
    end else if (issue) begin
      CMD_TYPE <= REQ_CMD;
      CMD_BG   <= REQ_BG;
      CMD_ADDR <= REQ_ADDR;
    end
  end

endmodule // dcs_spacing
`default_nettype wire

// ### testbench/dcs_spacing_sva.sv
// Port-level assertions for the command spacing gate
`timescale 1ns/10ps
`default_nettype none
`include "dcs_defs.vh"
module dcs_spacing_sva (
  input wire logic                    MCLK,
  input wire logic                    RESETN,
  input wire logic [1:0]              PAGE_SIZE,
  input wire logic                    REQ_VALID,
  input wire logic [1:0]              REQ_CMD,
  input wire logic [1:0]              REQ_BG,
  input wire logic [17:0]             REQ_ADDR,
  input wire logic                    REQ_READY,
  input wire logic                    CMD_VALID,
  input wire logic [1:0]              CMD_TYPE,
  input wire logic [1:0]              CMD_BG,
  input wire logic [17:0]             CMD_ADDR,
  input wire logic [`DCS_CAUSE_W-1:0] BLOCK_CAUSE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  wire take = REQ_VALID && REQ_READY;
  wire act_take = take && REQ_CMD == `DCS_CMD_ACT;
  // Shortest window is 16 cycles, so this bound holds on every page size
  logic [14:0] act_hist_q;
  always_ff @(posedge MCLK or negedge RESETN)
    if (!RESETN) act_hist_q <= 15'h0000;
    else act_hist_q <= {act_hist_q[13:0], act_take};
  take_pulse_a: assert property (take |=> CMD_VALID) else $error("accepted request gave no pulse");
  idle_quiet_a: assert property (!take |=> !CMD_VALID) else $error("pulse without accept");
  cmd_echo_a: assert property (take |=> CMD_TYPE == $past(REQ_CMD) && CMD_BG == $past(REQ_BG)
    && CMD_ADDR == $past(REQ_ADDR)) else $error("issued command differs from request");
  col_gap_a: assert property (CMD_VALID && CMD_TYPE[1] |-> (!REQ_CMD[1] || !REQ_READY) [*3])
    else $error("column command too soon");
  act_gap_a: assert property (CMD_VALID && CMD_TYPE == `DCS_CMD_ACT |->
    (REQ_CMD != `DCS_CMD_ACT || !REQ_READY) [*3]) else $error("activation too soon");
  faw_bound_a: assert property ($countones({act_hist_q, act_take}) <= 4)
    else $error("five activations in window");
  wtr_cause_a: assert property (CMD_VALID && CMD_TYPE == `DCS_CMD_WR && REQ_VALID && REQ_CMD == `DCS_CMD_RD
    && REQ_BG != CMD_BG |-> !REQ_READY ##1 BLOCK_CAUSE[5] && BLOCK_CAUSE[1]) else $error("read after write cause");
  other_free_a: assert property (REQ_CMD == `DCS_CMD_OTHER |-> REQ_READY)
    else $error("unchecked command held");
  cause_clear_a: assert property (!REQ_VALID || REQ_READY |=> BLOCK_CAUSE == 6'h00)
    else $error("cause without stall");
  stall_cause_a: assert property (REQ_VALID && !REQ_READY |=> BLOCK_CAUSE != 6'h00)
    else $error("stall without cause");
  col_stall_c: cover property (REQ_VALID && !REQ_READY && REQ_CMD[1]);
  faw_stall_c: cover property (BLOCK_CAUSE[4]);
  wtr_stall_c: cover property (BLOCK_CAUSE[5]);
endmodule // dcs_spacing_sva
`default_nettype wire

// ### testbench/dcs_dev_model.sv
// Device-side model that counts spacing violations of the issued commands
`timescale 1ns/10ps
`default_nettype none
`include "dcs_defs.vh"
module dcs_dev_model (
  input wire logic       MCLK,
  input wire logic       RESETN,
  input wire logic [1:0] PAGE_SIZE,
  input wire logic       CMD_VALID,
  input wire logic [1:0] CMD_TYPE,
  input wire logic [1:0] CMD_BG,
  output var logic [15:0] viol_cnt
);
  int cyc, wr_at, col_at[4], act_at[4];
  int acts[$];
  logic [1:0] wr_bg;
  function automatic int need(input int nck, input int ps);
    int c;
    c = (ps + 99999) / 100000;
    return (c > nck) ? c : nck;
  endfunction
  function automatic int pg(input int hk, input int k1, input int k2);
    return (PAGE_SIZE == 2'h0) ? hk : (PAGE_SIZE == 2'h1) ? k1 : k2;
  endfunction
  always @(posedge MCLK or negedge RESETN) begin : dev
    logic bad;
    if (!RESETN) begin
      cyc = 0;
      wr_at = -99;
      col_at = '{-99, -99, -99, -99};
      act_at = '{-99, -99, -99, -99};
      acts.delete();
      viol_cnt <= 16'h0000;
    end else begin
      cyc++;
      bad = 0;
      if (CMD_VALID) begin
        for (int g = 0; g < 4; g++) begin
          if (CMD_TYPE[1] && cyc - col_at[g] < ((g == CMD_BG) ? need(4, 5355) : 4)) bad = 1;
          if (CMD_TYPE == `DCS_CMD_ACT && cyc - act_at[g] < ((g == CMD_BG) ?
              pg(need(4, 5300), need(4, 5300), need(4, 6400)) : pg(need(4, 3700), need(4, 3700), need(4, 5300))))
            bad = 1;
        end
        if (CMD_TYPE == `DCS_CMD_RD && CMD_BG != wr_bg && cyc - wr_at < need(2, 2500)) bad = 1;
        if (CMD_TYPE == `DCS_CMD_ACT && acts.size() == 4 &&
            cyc - acts[0] < pg(need(16, 15000), need(20, 21000), need(28, 30000)))
          bad = 1;
        if (CMD_TYPE[1]) col_at[CMD_BG] = cyc;
        if (CMD_TYPE == `DCS_CMD_WR) begin
          wr_at = cyc;
          wr_bg = CMD_BG;
        end
        if (CMD_TYPE == `DCS_CMD_ACT) begin
          act_at[CMD_BG] = cyc;
          acts.push_back(cyc);
          if (acts.size() > 4) void'(acts.pop_front());
        end
      end
      if (bad) viol_cnt <= viol_cnt + 16'h0001;
    end
  end
endmodule // dcs_dev_model
`default_nettype wire

// ### testbench/dcs_spacing_tb.sv
// Self-checking bench for the command spacing gate
`timescale 1ns/10ps
`default_nettype none
`include "dcs_defs.vh"
module dcs_spacing_tb;
  typedef struct {logic [1:0] c; logic [1:0] b; logic [17:0] a; int gap;} dcs_exp_t;
  logic MCLK = 0, RESETN = 0, REQ_VALID = 0, REQ_READY, CMD_VALID;
  logic [1:0] PAGE_SIZE = 0, REQ_CMD = 0, REQ_BG = 0, CMD_TYPE, CMD_BG;
  logic [17:0] REQ_ADDR = 0, CMD_ADDR;
  logic [5:0] BLOCK_CAUSE;
  logic [15:0] viol_cnt;
  int error_cnt = 0, tests_run = 0, cyc = 0, last = 0, seed = 80;
  int fw[3] = '{`DCS_FAW_HK_NCK, `DCS_FAW_1K_NCK, `DCS_FAW_2K_NCK};
  dcs_exp_t exp_q[$];
  dcs_exp_t e;
  always #50 MCLK = ~MCLK;
  dcs_spacing u_dut (.MCLK(MCLK), .RESETN(RESETN), .PAGE_SIZE(PAGE_SIZE), .REQ_VALID(REQ_VALID),
    .REQ_CMD(REQ_CMD), .REQ_BG(REQ_BG), .REQ_ADDR(REQ_ADDR), .REQ_READY(REQ_READY), .CMD_VALID(CMD_VALID),
    .CMD_TYPE(CMD_TYPE), .CMD_BG(CMD_BG), .CMD_ADDR(CMD_ADDR), .BLOCK_CAUSE(BLOCK_CAUSE));
  dcs_dev_model u_dev (.MCLK(MCLK), .RESETN(RESETN), .PAGE_SIZE(PAGE_SIZE), .CMD_VALID(CMD_VALID),
    .CMD_TYPE(CMD_TYPE), .CMD_BG(CMD_BG), .viol_cnt(viol_cnt));
  task automatic check(input string nm, input logic [17:0] x, input logic [17:0] y);
    tests_run++;
    if (x !== y) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, x, y);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Called at a rising edge; the request is held until taken, so chained calls run back to back
  task automatic issue(input logic [1:0] c, input logic [1:0] b, input int gap);
    int n;
    logic [17:0] a;
    n = 0;
    a = 18'($random(seed));
    REQ_VALID <= 1'b1;
    REQ_CMD <= c;
    REQ_BG <= b;
    REQ_ADDR <= a;
    exp_q.push_back('{c, b, a, gap});
    @(negedge MCLK);
    while (REQ_READY !== 1'b1 && n < 100) begin
      @(negedge MCLK);
      n++;
    end
    if (n == 100) check("ready wait", 18'h0_0000, 18'h0_0001);
    @(posedge MCLK);
  endtask
  task automatic idle(input int n);
    REQ_VALID <= 1'b0;
    repeat (n) @(posedge MCLK);
  endtask
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  // Results are compared against the oldest outstanding request
  always @(negedge MCLK) if (CMD_VALID === 1'b1) begin
    if (exp_q.size() == 0) check("queue", 18'h0_0001, 18'h0_0000);
    else begin
      e = exp_q.pop_front();
      check("type", 18'(e.c), 18'(CMD_TYPE));
      check("group", 18'(e.b), 18'(CMD_BG));
      check("addr", e.a, CMD_ADDR);
      if (e.gap >= 0) check("gap", 18'(e.gap), 18'(cyc - last));
      last = cyc;
    end
  end
  initial begin
    repeat (20) @(posedge MCLK);
    RESETN <= 1'b1;
    @(posedge MCLK);
    for (int p = 0; p < 3; p++) begin
      PAGE_SIZE <= 2'(p);
      issue(`DCS_CMD_RD, 2'h0, -1);
      issue(`DCS_CMD_RD, 2'h1, 4);
      issue(`DCS_CMD_RD, 2'h1, 4);
      issue(`DCS_CMD_WR, 2'h2, 4);
      issue(`DCS_CMD_RD, 2'h3, 4);
      issue(`DCS_CMD_ACT, 2'h0, 1);
      issue(`DCS_CMD_ACT, 2'h0, 4);
      issue(`DCS_CMD_ACT, 2'h1, 4);
      issue(`DCS_CMD_ACT, 2'h2, 4);
      issue(`DCS_CMD_ACT, 2'h3, fw[p] - 12);
      issue(`DCS_CMD_OTHER, 2'h3, 1);
      idle(30);
    end
    // Random traffic; the device model judges the minimum spacing
    for (int i = 0; i < 400; i++) begin
      // Page size changes only once the window has drained
      if (i % 100 == 0) begin
        idle(30);
        PAGE_SIZE <= 2'($unsigned($random(seed)) % 3);
      end
      issue(2'($random(seed)), 2'($random(seed)), -1);
    end
    idle(5);
    check("violations", 18'h0_0000, 18'(viol_cnt));
    check("pending", 18'h0_0000, 18'(exp_q.size()));
    close_out();
  end
endmodule // dcs_spacing_tb
bind dcs_spacing dcs_spacing_sva u_sva (.MCLK(MCLK), .RESETN(RESETN), .PAGE_SIZE(PAGE_SIZE),
  .REQ_VALID(REQ_VALID), .REQ_CMD(REQ_CMD), .REQ_BG(REQ_BG), .REQ_ADDR(REQ_ADDR), .REQ_READY(REQ_READY),
  .CMD_VALID(CMD_VALID), .CMD_TYPE(CMD_TYPE), .CMD_BG(CMD_BG), .CMD_ADDR(CMD_ADDR), .BLOCK_CAUSE(BLOCK_CAUSE));
`default_nettype wire
